// ---- shared/flash_ctrl_consts.svh ----
// Offsets, field positions, codes and reset values of the flash controller.
// Included by the flash controller and the testbench; definitions only.
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH

// Register byte offsets inside the register space
`define OFS_MODE      8'h60
`define OFS_CMD       8'h64
`define OFS_STATUS    8'h68
`define OFS_LOCKS     8'h80

// Mode register fields
`define MODE_RDY_IE   0
`define MODE_LOCK_IE  2
`define MODE_NO_ERASE_BEFORE_PROGRAM     7
`define MODE_FWS_LO   8
`define MODE_MICROSECOND_CYCLES_LO  16
`define FWS_W         2
`define MICROSECOND_CYCLES_W        8

// Command register fields
`define CMD_CODE_W    4
`define CMD_PAGE_LO   8
`define CMD_KEY_LO    24
`define CMD_KEY_W     8
`define CMD_KEY       8'h5A

// Status register fields
`define STAT_READY    0
`define STAT_LOCK_ERROR_FLAG    2
`define STAT_KEY_ERROR_FLAG    3
`define STAT_SEC      4
`define STAT_NVM_LO   8

// Counts and values
`define NVM_BITS      3
`define NVM_IDX_W     2
`define WS_MAX        2'h3
`define WS_ZERO       2'h0
`define WS_STEP       2'h1
`define BUS_TMR_W     2
`define ERASED_WORD   32'hFFFFFFFF
`define READY_RESET   1'b1

`endif

// ---- shared/flash_ctrl_pkg.sv ----
// Types shared by the flash controller: command codes and sequencer states.
// Assumes nothing of its surroundings.
package flash_ctrl_pkg;

   // Command codes of the command register
   typedef enum logic [3:0] {
      CMD_WRITE_PAGE           = 4'h1,
      CMD_SET_LOCK_BIT         = 4'h2,
      CMD_WRITE_PAGE_THEN_LOCK = 4'h3,
      CMD_CLEAR_LOCK_BIT       = 4'h4,
      CMD_ERASE_ALL            = 4'h8,
      CMD_SET_NVM_BIT          = 4'hB,
      CMD_CLEAR_NVM_BIT        = 4'hD,
      CMD_SET_SECURITY_BIT     = 4'hF
   } command_code_e;

   // Command sequencer states
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WALK  = 2'b01,
      ST_DWELL = 2'b10,
      ST_DONE  = 2'b11
   } seq_state_e;

endpackage

// ---- rtl/flash_cycle_timer.sv ----
// Down counter: loads a value, counts to zero, flags expiry.
// Assumes one clock and an asynchronous active-high reset.
module flash_cycle_timer #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] loadValue,
   // Status
   output logic              expired
);

   typedef struct packed {
      logic [W-1:0] count;
   } timer_s;

   timer_s timerReg;
   timer_s timerNext;

   // Load or count down
   always_comb begin
      timerNext = timerReg;
      if (load) begin
         timerNext.count = loadValue;
      end else if (timerReg.count != '0) begin
         timerNext.count = timerReg.count - W'(1);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         timerReg <= '0;
      end else begin
         timerReg <= timerNext;
      end
   end

   assign expired = (timerReg.count == '0);

endmodule // flash_cycle_timer

// ---- rtl/embedded_flash_command_ctrl.sv ----
// Embedded flash controller: wait-stated reads with code prefetch, page latch,
// keyed command sequencer with lock, NVM and security bits.
// Assumes a classic Wishbone master, one clock, asynchronous active-high reset.
//
// Summary of operation
// - Two word buffers prefetch the following word, only for instruction fetches.
// - Reads insert 0 to 3 wait states from the wait-state field.
// - With one wait state, sequential fetches take one cycle after the first.
// - With two or three, sequential fetches alternate full latency and one cycle.
// - Flash image mirrors across the region; byte, halfword, word reads accepted.
// - Latch writes decode only the eight lowest address bits.
// - Latch writes take one wait state more than reads, except at three.
// - Command codes decode as the eight documented values.
// - Command write clears ready; completion sets it and may raise the interrupt.
// - Bad key or code leaves flash alone, sets program error; status read clears.
// - Page write hitting a locked region changes nothing, sets lock error; read clears.
// - With no-erase bit clear, the page is erased before programming.
// - With no-erase bit set, the page is programmed without erasing.
// - Write-page-then-lock programs the page, then locks its region.
// - Programming starts at once when the command write arrives.
// - Erase all runs only with no lock set; else lock error, nothing erased.
// - One lock bit per region of pages, and three NVM bits.
// - Secondary controller has no security or NVM bits.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`include "flash_ctrl_consts.svh"

module embedded_flash_command_ctrl
   import flash_ctrl_pkg::*;
#(
   parameter int PAGES      = 1024,
   parameter int PAGE_WORDS = 64,
   parameter int LOCK_BITS  = 16,
   parameter int ADR_W      = 24,
   parameter bit HAS_NVM    = 1'b1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Wishbone slave
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [31:0]      wb_dat_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic             wb_we_i,
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   output logic [31:0]           wb_dat_o,
   output logic                  wb_ack_o,
   // Marks the request as an instruction fetch
   input  wire logic             instrFetch,
   // Interrupt line
   output logic                  irq
);

   localparam int WORDS = PAGES * PAGE_WORDS;
   localparam int AW    = $clog2(WORDS);
   localparam int PW    = $clog2(PAGES);
   localparam int LW    = $clog2(PAGE_WORDS);
   localparam int LBW   = $clog2(LOCK_BITS);

   typedef struct packed {
      seq_state_e              st;
      logic                    busPend;
      logic                    ack;
      logic [31:0]             dat;
      logic [`FWS_W-1:0]       flash_wait_states;
      logic [`MICROSECOND_CYCLES_W-1:0]      microsecond_cycles;
      logic                    no_erase_before_program;
      logic                    rdyIe;
      logic                    lockIe;
      logic                    ready;
      logic                    progErr;
      logic                    lockErr;
      logic                    security;
      logic [`NVM_BITS-1:0]    nvm;
      logic [LOCK_BITS-1:0]    locks;
      logic                    irq;
      command_code_e           code;
      logic [PW-1:0]           page;
      logic [AW-1:0]           walk;
      logic [AW-1:0]           walkEnd;
      logic [AW-1:0]           pfCur;
      logic [AW-1:0]           pfNext;
      logic                    pfCurValid;
      logic                    pfNextValid;
   } ctrl_s;

   ctrl_s                  stateReg;
   ctrl_s                  stateNext;
   logic [31:0]            flashArray [WORDS];
   logic [31:0]            pageLatch  [PAGE_WORDS];
   logic                   isRegSpace;
   logic [7:0]             regOfs;
   logic [AW-1:0]          wordIdx;
   logic [LW-1:0]          latchIdx;
   logic                   take;
   logic                   ackEdge;
   logic                   pfHit;
   logic [`BUS_TMR_W-1:0]  busWaits;
   logic                   busExpired;
   logic                   dwellLoad;
   logic                   dwellExpired;
   logic                   memWe;
   logic [AW-1:0]          memIdx;
   logic [31:0]            memData;
   logic                   latchWe;
   logic                   keyOk;
   logic                   codeOk;
   logic [`CMD_CODE_W-1:0] cmdCode;
   logic [PW-1:0]          cmdPage;
   logic                   cmdAccept;
   logic                   statusRead;

   // Address decode; flash and latch indices drop the upper bits
   assign isRegSpace = wb_adr_i[ADR_W-1];
   assign regOfs     = wb_adr_i[7:0];
   assign wordIdx    = wb_adr_i[AW+1:2];
   assign latchIdx   = wb_adr_i[LW+1:2];
   assign take       = wb_cyc_i && wb_stb_i && !stateReg.busPend && !stateReg.ack;
   // Zero wait states answer at the take edge; otherwise when the timer runs out
   assign ackEdge    = (take && (busWaits == `WS_ZERO)) || (stateReg.busPend && busExpired);

   // Fetch hits the current word or the prefetched following word
   assign pfHit = instrFetch && !wb_we_i && !isRegSpace && (stateReg.st == ST_IDLE)
                  && ((stateReg.pfCurValid && (wordIdx == stateReg.pfCur))
                  || (stateReg.pfNextValid && (wordIdx == stateReg.pfNext)));

   // Wait states of the access being taken
   always_comb begin
      if (isRegSpace || pfHit) begin
         busWaits = `WS_ZERO;
      end else if (wb_we_i) begin
         busWaits = (stateReg.flash_wait_states == `WS_MAX) ? `WS_MAX
                    : `BUS_TMR_W'(stateReg.flash_wait_states + `WS_STEP);
      end else begin
         busWaits = stateReg.flash_wait_states;
      end
   end

   // Command word fields
   assign cmdCode    = wb_dat_i[`CMD_CODE_W-1:0];
   assign cmdPage    = wb_dat_i[`CMD_PAGE_LO +: PW];
   assign keyOk      = (wb_dat_i[`CMD_KEY_LO +: `CMD_KEY_W] == `CMD_KEY);
   assign cmdAccept  = ackEdge && isRegSpace && wb_we_i && (regOfs == `OFS_CMD)
                       && stateReg.ready;
   assign statusRead = ackEdge && isRegSpace && !wb_we_i && (regOfs == `OFS_STATUS);

   // Valid codes; the secondary controller lacks NVM and security commands
   always_comb begin
      case (cmdCode)
         CMD_WRITE_PAGE, CMD_SET_LOCK_BIT, CMD_WRITE_PAGE_THEN_LOCK,
         CMD_CLEAR_LOCK_BIT, CMD_ERASE_ALL: codeOk = 1'b1;
         CMD_SET_NVM_BIT, CMD_CLEAR_NVM_BIT,
         CMD_SET_SECURITY_BIT: codeOk = HAS_NVM;
         default: codeOk = 1'b0;
      endcase
   end

   // Bus latency counter
   flash_cycle_timer #(
      .W         (`BUS_TMR_W)
   ) busTimer (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .load      (take),
      .loadValue (`BUS_TMR_W'(busWaits - `WS_STEP)), // Take edge is the first wait state
      .expired   (busExpired)
   );

   // Operation dwell counter, scaled by the microsecond cycle field
   flash_cycle_timer #(
      .W         (`MICROSECOND_CYCLES_W)
   ) dwellTimer (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .load      (dwellLoad),
      .loadValue (stateReg.microsecond_cycles),
      .expired   (dwellExpired)
   );

   // Next state: bus accesses, then the command sequencer
   always_comb begin
      stateNext = stateReg;
      memWe     = 1'b0;
      memIdx    = stateReg.walk;
      memData   = `ERASED_WORD;
      latchWe   = 1'b0;
      dwellLoad = 1'b0;
      stateNext.ack = 1'b0;
      if (take) begin
         stateNext.busPend = 1'b1;
      end
      if (ackEdge) begin
         stateNext.busPend = 1'b0;
         stateNext.ack     = 1'b1;
         stateNext.dat     = '0;
         if (isRegSpace && wb_we_i) begin
            if (regOfs == `OFS_MODE) begin
               stateNext.rdyIe  = wb_dat_i[`MODE_RDY_IE];
               stateNext.lockIe = wb_dat_i[`MODE_LOCK_IE];
               stateNext.no_erase_before_program   = wb_dat_i[`MODE_NO_ERASE_BEFORE_PROGRAM];
               stateNext.flash_wait_states    = wb_dat_i[`MODE_FWS_LO +: `FWS_W];
               stateNext.microsecond_cycles   = wb_dat_i[`MODE_MICROSECOND_CYCLES_LO +: `MICROSECOND_CYCLES_W];
            end else if (cmdAccept) begin
               stateNext.ready = 1'b0;
               stateNext.code  = command_code_e'(cmdCode);
               stateNext.page  = cmdPage;
               stateNext.st    = ST_DONE;
               if (!keyOk || !codeOk) begin
                  stateNext.progErr = 1'b1;
               end else begin
                  case (cmdCode)
                     CMD_WRITE_PAGE, CMD_WRITE_PAGE_THEN_LOCK: begin
                        if (stateReg.locks[cmdPage[PW-1 -: LBW]]) begin
                           stateNext.lockErr = 1'b1;
                        end else begin
                           stateNext.walk        = {cmdPage, {LW{1'b0}}};
                           stateNext.walkEnd     = {cmdPage, {LW{1'b1}}};
                           stateNext.st          = ST_WALK;
                           stateNext.pfCurValid  = 1'b0;
                           stateNext.pfNextValid = 1'b0;
                        end
                     end
                     CMD_ERASE_ALL: begin
                        if (|stateReg.locks) begin
                           stateNext.lockErr = 1'b1;
                        end else begin
                           stateNext.walk        = '0;
                           stateNext.walkEnd     = '1;
                           stateNext.st          = ST_WALK;
                           stateNext.pfCurValid  = 1'b0;
                           stateNext.pfNextValid = 1'b0;
                        end
                     end
                     CMD_SET_LOCK_BIT, CMD_CLEAR_LOCK_BIT: begin
                        stateNext.locks[cmdPage[PW-1 -: LBW]] =
                           (cmdCode == CMD_SET_LOCK_BIT);
                        stateNext.st = ST_DWELL;
                        dwellLoad    = 1'b1;
                     end
                     CMD_SET_NVM_BIT, CMD_CLEAR_NVM_BIT: begin
                        if (cmdPage < PW'(`NVM_BITS)) begin
                           stateNext.nvm[cmdPage[`NVM_IDX_W-1:0]] =
                              (cmdCode == CMD_SET_NVM_BIT);
                        end
                        stateNext.st = ST_DWELL;
                        dwellLoad    = 1'b1;
                     end
                     CMD_SET_SECURITY_BIT: begin
                        stateNext.security = 1'b1;
                        stateNext.st       = ST_DWELL;
                        dwellLoad          = 1'b1;
                     end
                     default: stateNext.st = ST_DONE;
                  endcase
               end
            end
         end else if (isRegSpace) begin
            case (regOfs)
               `OFS_MODE: begin
                  stateNext.dat[`MODE_RDY_IE]                = stateReg.rdyIe;
                  stateNext.dat[`MODE_LOCK_IE]               = stateReg.lockIe;
                  stateNext.dat[`MODE_NO_ERASE_BEFORE_PROGRAM]                  = stateReg.no_erase_before_program;
                  stateNext.dat[`MODE_FWS_LO +: `FWS_W]      = stateReg.flash_wait_states;
                  stateNext.dat[`MODE_MICROSECOND_CYCLES_LO +: `MICROSECOND_CYCLES_W]    = stateReg.microsecond_cycles;
               end
               `OFS_STATUS: begin
                  stateNext.dat[`STAT_READY]                 = stateReg.ready;
                  stateNext.dat[`STAT_LOCK_ERROR_FLAG]                 = stateReg.lockErr;
                  stateNext.dat[`STAT_KEY_ERROR_FLAG]                 = stateReg.progErr;
                  stateNext.dat[`STAT_SEC]                   = stateReg.security;
                  stateNext.dat[`STAT_NVM_LO +: `NVM_BITS]   = stateReg.nvm;
                  stateNext.progErr = 1'b0;
                  stateNext.lockErr = 1'b0;
               end
               `OFS_LOCKS: stateNext.dat[LOCK_BITS-1:0] = stateReg.locks;
               default: stateNext.dat = '0;
            endcase
         end else if (wb_we_i) begin
            latchWe = 1'b1;
         end else begin
            stateNext.dat = flashArray[wordIdx];
            if (instrFetch && (stateReg.st == ST_IDLE)) begin
               if (stateReg.pfNextValid && (wordIdx == stateReg.pfNext)) begin
                  stateNext.pfCur       = stateReg.pfNext;
                  stateNext.pfNext      = AW'(stateReg.pfNext + AW'(1));
                  stateNext.pfNextValid = (stateReg.flash_wait_states <= `WS_STEP);
               end else if (!(stateReg.pfCurValid && (wordIdx == stateReg.pfCur))) begin
                  stateNext.pfCur       = wordIdx;
                  stateNext.pfNext      = AW'(wordIdx + AW'(1));
                  stateNext.pfNextValid = 1'b1;
               end
               stateNext.pfCurValid = 1'b1;
            end
         end
      end
      // Command sequencer
      case (stateReg.st)
         ST_WALK: begin
            memWe = 1'b1;
            if (stateReg.code == CMD_ERASE_ALL) begin
               memData = `ERASED_WORD;
            end else if (stateReg.no_erase_before_program) begin
               memData = flashArray[stateReg.walk] & pageLatch[stateReg.walk[LW-1:0]];
            end else begin
               memData = pageLatch[stateReg.walk[LW-1:0]];
            end
            if (stateReg.walk == stateReg.walkEnd) begin
               stateNext.st = ST_DWELL;
               dwellLoad    = 1'b1;
               if (stateReg.code == CMD_WRITE_PAGE_THEN_LOCK) begin
                  stateNext.locks[stateReg.page[PW-1 -: LBW]] = 1'b1;
               end
            end else begin
               stateNext.walk = AW'(stateReg.walk + AW'(1));
            end
         end
         ST_DWELL: begin
            if (dwellExpired) begin
               stateNext.st = ST_DONE;
            end
         end
         ST_DONE: begin
            stateNext.ready = 1'b1;
            stateNext.st    = ST_IDLE;
         end
         default: begin
         end
      endcase
      stateNext.irq = (stateNext.rdyIe && stateNext.ready)
                      || (stateNext.lockIe && stateNext.lockErr);
   end

   // State register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stateReg       <= '0;
         stateReg.ready <= `READY_RESET;
      end else begin
         stateReg <= stateNext;
      end
   end

   // Flash plane and page latch storage
   always_ff @(posedge clk) begin
      if (memWe) begin
         flashArray[memIdx] <= memData;
      end
      if (latchWe) begin
         pageLatch[latchIdx] <= wb_dat_i;
      end
   end

   assign wb_dat_o = stateReg.dat;
   assign wb_ack_o = stateReg.ack;
   assign irq      = stateReg.irq;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence flashReadTake;
      take && !wb_we_i && !isRegSpace && !pfHit;
   endsequence

   sequence ackAfterTwoIdle;
      !wb_ack_o [*2] ##1 wb_ack_o;
   endsequence

   AST_READ_WS0: assert property (
      flashReadTake ##0 (stateReg.flash_wait_states == 2'h0) |-> ##1 wb_ack_o)
      else $error("zero wait state read not answered in one cycle");
   AST_FETCH_HIT: assert property (
      take && pfHit |-> ##1 wb_ack_o)
      else $error("prefetch hit not answered in one cycle");
   AST_READ_WS2: assert property (
      flashReadTake ##0 (stateReg.flash_wait_states == 2'h2) |-> ##1 ackAfterTwoIdle)
      else $error("two wait state read latency wrong");
   AST_WRITE_WS1: assert property (
      take && wb_we_i && !isRegSpace && (stateReg.flash_wait_states == 2'h1) |-> ##1 ackAfterTwoIdle)
      else $error("latch write latency wrong");
   AST_CMD_CLEARS_READY: assert property (
      cmdAccept |=> !stateReg.ready)
      else $error("ready not cleared by command");
   AST_READY_IRQ: assert property (
      $rose(stateReg.ready) && stateReg.rdyIe |-> irq)
      else $error("ready interrupt missing");
   AST_BAD_KEY: assert property (
      cmdAccept && !keyOk |=> stateReg.progErr && (stateReg.st == ST_DONE))
      else $error("bad key not flagged");
   AST_STATUS_CLEARS: assert property (
      statusRead |=> !stateReg.progErr && !stateReg.lockErr)
      else $error("status read did not clear errors");
   AST_ERASE_LOCKED: assert property (
      cmdAccept && keyOk && (cmdCode == CMD_ERASE_ALL) && (|stateReg.locks)
      |=> stateReg.lockErr && (stateReg.st == ST_DONE))
      else $error("erase all ran with a lock set");
   AST_IDLE_READY: assert property (
      (stateReg.st == ST_IDLE) |-> stateReg.ready)
      else $error("idle without ready");

endmodule // embedded_flash_command_ctrl

// ---- sim/wb_master_model.sv ----
// Classic Wishbone master standing in for the processor side of the flash controller.
// Assumes one clock; the bench calls xfer for each single access.
module wb_master_model (
   // Clock
   input  wire logic        clk,
   // Bus towards the controller
   output logic [23:0]      adr,
   output logic [31:0]      datW,
   output logic [3:0]       sel,
   output logic             we,
   output logic             cyc,
   output logic             stb,
   output logic             fetch,
   input  wire logic [31:0] datR,
   input  wire logic        ack
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle bus at time zero
   initial begin
      adr = '0;
      datW = '0;
      sel = 4'hF;
      we = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      fetch = 1'b0;
   end

   // One access; lat counts rising edges from launch to the one that samples ack
   task automatic xfer(input logic w, input logic [23:0] a, input logic [31:0] d,
                       input logic f, output logic [31:0] q, output int lat);
      @(posedge clk);
      adr <= a;
      datW <= d;
      we <= w;
      fetch <= f;
      sel <= 4'hF;
      cyc <= 1'b1;
      stb <= 1'b1;
      lat = 0;
      // Sample ack at each rising edge; take data and release at that same edge
      do begin
         @(posedge clk);
         lat++;
      end while (ack !== 1'b1);
      q = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      fetch <= 1'b0;
      datW <= ~d; // Released data no longer shows the old word
   endtask
endmodule // wb_master_model

// ---- sim/testbench.sv ----
// Self-checking bench of the flash controller: reads, latch, commands, locks, NVM bits.
// Assumes the master model and the controller with 256 pages of 64 words.
`include "flash_ctrl_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD %s exp %h seen %h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import flash_ctrl_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, ack, irq;
   logic [23:0] adr;
   logic [31:0] datW, datR, rd, st;
   logic [3:0] sel;
   logic we, cyc, stb, fetch;
   int lat, bad_count = 0, total_checks = 0;

   // Clock of 100 ns period
   initial forever #50 clk = ~clk;

   wb_master_model m (.clk(clk), .adr(adr), .datW(datW), .sel(sel), .we(we), .cyc(cyc),
      .stb(stb), .fetch(fetch), .datR(datR), .ack(ack));
   embedded_flash_command_ctrl #(.PAGES(256)) dut (.clk(clk), .sys_rst(sys_rst),
      .wb_adr_i(adr), .wb_dat_i(datW), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_dat_o(datR), .wb_ack_o(ack), .instrFetch(fetch), .irq(irq));

   function automatic logic [31:0] pat(int p, int i);
      return 32'hC3000000 | 32'(p << 8) | 32'(i);
   endfunction
   function automatic logic [23:0] fa(int p, int i);
      return 24'(p * 256 + i * 4);
   endfunction
   // Mode word: cycle count 2, ready interrupt on
   function automatic logic [31:0] md(int flash_wait_states, int no_erase_before_program);
      return (32'h2 << `MODE_MICROSECOND_CYCLES_LO) | 32'(flash_wait_states << `MODE_FWS_LO)
             | 32'(no_erase_before_program << `MODE_NO_ERASE_BEFORE_PROGRAM) | 32'h1;
   endfunction

   // Bus helpers
   task automatic acc(logic w, logic [23:0] a, logic [31:0] d, logic f);
      m.xfer(w, a, d, f, rd, lat);
   endtask
   task automatic regr(logic [7:0] o);
      acc(1'b0, 24'h800000 | 24'(o), '0, 1'b0);
   endtask
   task automatic cmd(logic [3:0] c, int pg, logic [7:0] key = `CMD_KEY);
      acc(1'b1, 24'h800000 | 24'(`OFS_CMD),
          (32'(key) << 24) | 32'(pg << 8) | 32'(c), 1'b0);
   endtask
   task automatic waitReady;
      for (int n = 0; n < 9000; n++) begin
         regr(`OFS_STATUS);
         st = rd;
         if (rd[0] === 1'b1) break;
      end
      `CHK("ready wait", 1'b1, st[0])
   endtask
   task automatic fill(int p, logic [31:0] msk);
      for (int i = 0; i < 64; i++) acc(1'b1, fa(p, i), pat(3, i) & msk, 1'b0);
   endtask

   // Scenarios
   task automatic t_reset;
      regr(`OFS_MODE);
      `CHK("mode", 32'h0, rd)
      regr(`OFS_STATUS);
      `CHK("status", 32'h1, rd)
      regr(`OFS_LOCKS);
      `CHK("locks", 32'h0, rd)
      regr(8'h70);
      `CHK("unmapped", 32'h0, rd)
   endtask
   task automatic t_program;
      acc(1'b1, 24'h800000 | 24'(`OFS_MODE), md(0, 0), 1'b0);
      fill(7, 32'hFFFFFFFF);
      cmd(CMD_WRITE_PAGE, 3);
      regr(`OFS_STATUS);
      `CHK("busy", 1'b0, rd[0])
      waitReady();
      `CHK("done", 32'h1, st)
      `CHK("irq", 1'b1, irq)
      acc(1'b0, fa(3, 63) + 24'h10000, '0, 1'b0);
      `CHK("mirror", pat(3, 63), rd)
      acc(1'b1, 24'h800000 | 24'(`OFS_MODE), md(0, 1), 1'b0);
      fill(3, 32'hFFFF00FF);
      cmd(CMD_WRITE_PAGE, 3);
      waitReady();
      acc(1'b0, fa(3, 5), '0, 1'b0);
      `CHK("no_erase_before_program", pat(3, 5) & 32'hFFFF00FF, rd)
   endtask
   task automatic t_timing;
      for (int f = 0; f < 4; f++) begin
         acc(1'b1, 24'h800000 | 24'(`OFS_MODE), md(f, 1), 1'b0);
         for (int k = 0; k < 4; k++) begin
            acc(1'b0, fa(3, 8 * f + k), '0, 1'b1);
            `CHK("fetch lat", (k[0] || (f == 1 && k > 0)) ? 2 : 2 + f, lat)
            `CHK("fetch data", pat(3, 8 * f + k) & 32'hFFFF00FF, rd)
         end
         acc(1'b0, fa(3, 8 * f + 1), '0, 1'b0);
         `CHK("data lat", 2 + f, lat)
         acc(1'b1, fa(3, 0), '0, 1'b0);
         `CHK("write lat", (f == 3) ? 5 : 3 + f, lat)
      end
   endtask
   task automatic t_errors;
      cmd(CMD_WRITE_PAGE, 3, 8'hA5);
      waitReady();
      `CHK("bad key", 32'h9, st)
      cmd(4'h5, 3);
      waitReady();
      `CHK("bad code", 32'h9, st)
      regr(`OFS_STATUS);
      `CHK("cleared", 32'h1, rd)
   endtask
   task automatic t_locks;
      acc(1'b1, 24'h800000 | 24'(`OFS_MODE), md(0, 0), 1'b0);
      cmd(CMD_SET_LOCK_BIT, 16);
      waitReady();
      cmd(CMD_WRITE_PAGE, 17);
      waitReady();
      `CHK("lock err", 32'h5, st)
      fill(3, 32'hFFFFFFFF);
      cmd(CMD_WRITE_PAGE_THEN_LOCK, 3);
      waitReady();
      regr(`OFS_LOCKS);
      `CHK("locks", 32'h3, rd)
      cmd(CMD_ERASE_ALL, 0);
      waitReady();
      `CHK("ea locked", 32'h5, st)
      acc(1'b0, fa(3, 9), '0, 1'b0);
      `CHK("kept", pat(3, 9), rd)
      cmd(CMD_CLEAR_LOCK_BIT, 16);
      waitReady();
      cmd(CMD_CLEAR_LOCK_BIT, 3);
      waitReady();
      cmd(CMD_ERASE_ALL, 0);
      waitReady();
      acc(1'b0, fa(3, 9), '0, 1'b0);
      `CHK("erased", `ERASED_WORD, rd)
      cmd(CMD_SET_NVM_BIT, 1);
      waitReady();
      cmd(CMD_SET_SECURITY_BIT, 0);
      waitReady();
      `CHK("nvm sec", 32'h211, st)
      cmd(CMD_CLEAR_NVM_BIT, 1);
      waitReady();
      `CHK("nvm clr", 32'h11, st)
   endtask

   task automatic wrap_up;
      if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Watchdog well above the expected run length
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      wrap_up();
   end

   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      `CHK("irq rst", 1'b0, irq)
      t_reset();
      t_program();
      t_timing();
      t_errors();
      t_locks();
      wrap_up();
   end
endmodule // testbench
